//--- src/modem_regs_pkg.sv
package modem_regs_pkg;

    // ----------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_CARRIER_RETURN = 8'h37;
    localparam logic [7:0] IDX_CARRIER_WAIT   = 8'h39;
    localparam logic [7:0] IDX_ANSWER_DELAY   = 8'h3A;
    localparam logic [7:0] IDX_CALLER_ID      = 8'h3C;
    localparam logic [7:0] IDX_RING_CONFIG    = 8'h62;
    localparam logic [7:0] IDX_INTRUSION      = 8'h82;
    localparam logic [7:0] IDX_LINE_VOLTAGE   = 8'hDB;
    localparam logic [7:0] IDX_GAIN_SELECT    = 8'hDF;
    localparam logic [7:0] IDX_CONFIG_ONE     = 8'hE0;
    localparam logic [7:0] IDX_PIN_FUNC_A     = 8'hE1;
    localparam logic [7:0] IDX_PIN_FUNC_B     = 8'hE2;
    localparam logic [7:0] IDX_PIN_DATA       = 8'hE3;
    localparam logic [7:0] IDX_CONFIG_FIVE    = 8'hE4;
    localparam logic [7:0] IDX_DSP_WINDOW_LOW = 8'hE5;
    localparam logic [7:0] IDX_DSP_WINDOW_HI  = 8'hE6;
    localparam logic [7:0] IDX_DSP_SELECT     = 8'hE8;
    localparam logic [7:0] IDX_TEST_POWER     = 8'hEB;

    localparam int ADDR_IDX_LSB = 2;
    localparam int ADDR_IDX_MSB = 9;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_CARRIER_RETURN = 8'h20;
    localparam logic [7:0] RST_CARRIER_WAIT   = 8'h3C;
    localparam logic [7:0] RST_ANSWER_DELAY   = 8'h00;
    localparam logic [7:0] RST_CALLER_ID      = 8'h01;
    localparam logic [7:0] RST_RING_CONFIG    = 8'h41;
    localparam logic [7:0] RST_INTRUSION      = 8'h08;
    localparam logic [7:0] RST_GAIN_SELECT    = 8'h0C;
    localparam logic [7:0] RST_CONFIG_ONE     = 8'h22;
    localparam logic [7:0] RST_PIN_FUNC_A     = 8'h0E;
    localparam logic [7:0] RST_PIN_FUNC_B     = 8'h00;
    localparam logic [7:0] RST_PIN_DATA       = 8'h00;
    localparam logic [7:0] RST_CONFIG_FIVE    = 8'h00;
    localparam logic [7:0] RST_DSP_SELECT     = 8'h00;
    localparam logic [7:0] RST_TEST_POWER     = 8'h00;

    // ----------------------------------------------------------------
    // Window selector meanings and field limits
    // ----------------------------------------------------------------
    localparam logic [7:0] SEL_ADDRESS = 8'h00;
    localparam logic [7:0] SEL_DATA    = 8'h01;
    localparam logic [7:0] SEL_CONTROL = 8'h02;
    localparam int         WORD_HI_W   = 6;
    localparam logic signed [7:0] MIN_VOLTS = 8'sh03;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS        = 50;
    localparam int RETURN_UNIT_NUM_NS   = 5000000; // 5/3 ms
    localparam int RETURN_UNIT_DEN      = 3;
    localparam int WAIT_UNIT_MS         = 1000;
    localparam int ANSWER_UNIT_US       = 53330;
    // Least times: round up
    localparam int RETURN_UNIT_CYC = (RETURN_UNIT_NUM_NS + RETURN_UNIT_DEN * CLK_PERIOD_NS - 1)
                                     / (RETURN_UNIT_DEN * CLK_PERIOD_NS);
    localparam int WAIT_UNIT_CYC   = (WAIT_UNIT_MS * 1000000) / CLK_PERIOD_NS;
    localparam int ANSWER_UNIT_CYC = (ANSWER_UNIT_US * 1000 + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;
    localparam int PRESCALE_W = 25;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] addr;
        logic [13:0] word;
        logic [7:0]  ctrl_low;
        logic [7:0]  ctrl_high;
        logic        word_load;
    } dsp_port_t;

    typedef struct packed {
        logic [PRESCALE_W-1:0] pre;
        logic [7:0]            units;
    } timer_t;

    typedef struct packed {
        logic        dphase_valid;
        logic        dphase_write;
        logic [7:0]  dphase_idx;
        logic [31:0] rdata;
        logic [7:0]  carrier_return_time;
        logic [7:0]  carrier_wait_timeout;
        logic [7:0]  answer_tone_delay;
        logic [7:0]  caller_id_bits;
        logic [7:0]  ring_config_bits;
        logic [7:0]  intrusion_bits;
        logic [7:0]  line_voltage_status;
        logic [7:0]  gain_select_bits;
        logic [7:0]  config_one_bits;
        logic [7:0]  pin_function_a;
        logic [7:0]  pin_function_b;
        logic [7:0]  pin_data_bits;
        logic [7:0]  config_five_bits;
        logic [7:0]  dsp_window_select;
        logic [7:0]  test_power_bits;
        dsp_port_t   dsp;
        timer_t      ret_tmr;
        timer_t      wait_tmr;
        timer_t      ans_tmr;
        logic        carrier_ok;
        logic        call_abort;
        logic        abort_done;
        logic        answer_tone_on;
    } state_t;

endpackage

//--- src/modem_timing_regs.sv
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// [RULE1] Returning carrier accepted after continuous detection for count times 5/3 ms.
// [RULE2] Call aborts when no carrier within count times one second.
// [RULE3] Answer mode: answer tone starts count times 53.33 ms after off-hook.
// [RULE4] Line voltage reads signed two's complement, one volt per LSB.
// [RULE5] Line voltage reads zero when below three volts.
// [RULE6] Window selector sets meaning of the two shared DSP offsets.
// [RULE7] Selector zero: low offset write loads DSP address bits 7 to 0.
// [RULE8] Selector zero: high offset write loads DSP address bits 15 to 8.
// [RULE9] Selector one: low offset write loads DSP data bits 7 to 0.
// [RULE10] Selector one: high offset write loads DSP data bits 13 to 8.
// [RULE11] Selector two: low offset read returns DSP status.
// [RULE12] Selector two: shared offset writes go to two DSP control registers.
// [RULE13] Shared offset reads at selector zero or one are undefined.
// [RULE14] Software sets selector first and completes byte pairs before changing it.

module modem_timing_regs #(
    parameter int RETURN_UNIT_CYC = modem_regs_pkg::RETURN_UNIT_CYC,
    parameter int WAIT_UNIT_CYC   = modem_regs_pkg::WAIT_UNIT_CYC,
    parameter int ANSWER_UNIT_CYC = modem_regs_pkg::ANSWER_UNIT_CYC
) (
    input  wire logic                      clk,
    input  wire logic                      nrst,
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic                      hready,
    input  wire logic [31:0]               hwdata,
    output logic [31:0]                    hrdata,
    output logic                           hreadyout,
    output logic                           hresp,
    input  wire logic                      carrier_detect,
    input  wire logic                      carrier_wait,
    input  wire logic                      answer_mode,
    input  wire logic                      off_hook,
    input  wire logic signed [7:0]         line_volts,
    input  wire logic [7:0]                dsp_status,
    output modem_regs_pkg::dsp_port_t      dsp,
    output logic                           carrier_ok,
    output logic                           call_abort,
    output logic                           answer_tone_on
);

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    localparam logic [modem_regs_pkg::PRESCALE_W-1:0] RET_LAST =
        modem_regs_pkg::PRESCALE_W'(RETURN_UNIT_CYC - 1);
    localparam logic [modem_regs_pkg::PRESCALE_W-1:0] WAIT_LAST =
        modem_regs_pkg::PRESCALE_W'(WAIT_UNIT_CYC - 1);
    localparam logic [modem_regs_pkg::PRESCALE_W-1:0] ANS_LAST =
        modem_regs_pkg::PRESCALE_W'(ANSWER_UNIT_CYC - 1);

    // Advance a unit timer by one clock; units saturate at the limit
    function automatic modem_regs_pkg::timer_t tick(
        input modem_regs_pkg::timer_t                t,
        input logic [modem_regs_pkg::PRESCALE_W-1:0] last,
        input logic [7:0]                            limit
    );
        modem_regs_pkg::timer_t r;
        r = t;
        if (t.units != limit) begin
            if (t.pre == last) begin
                r.pre   = '0;
                r.units = t.units + 8'h01;
            end else begin
                r.pre = t.pre + 1'b1;
            end
        end
        return r;
    endfunction

    function automatic logic is_reg(input logic [7:0] idx, input logic [7:0] which);
        return idx == which;
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    modem_regs_pkg::state_t st;
    modem_regs_pkg::state_t next_st;

    logic        aphase;
    logic [7:0]  a_idx;
    logic        a_mapped;
    logic [7:0]  w_idx;
    logic [7:0]  wb;
    logic        wr;
    logic [31:0] rd_val;

    assign aphase   = hsel && htrans[1] && hready;
    assign a_idx    = haddr[modem_regs_pkg::ADDR_IDX_MSB:modem_regs_pkg::ADDR_IDX_LSB];
    assign a_mapped = (haddr[31:modem_regs_pkg::ADDR_IDX_MSB+1] == '0);
    assign w_idx    = st.dphase_idx;
    assign wb       = hwdata[7:0];
    assign wr       = st.dphase_valid && st.dphase_write;

    localparam modem_regs_pkg::state_t RST_ST = '{
        carrier_return_time:  modem_regs_pkg::RST_CARRIER_RETURN,
        carrier_wait_timeout: modem_regs_pkg::RST_CARRIER_WAIT,
        answer_tone_delay:    modem_regs_pkg::RST_ANSWER_DELAY,
        caller_id_bits:       modem_regs_pkg::RST_CALLER_ID,
        ring_config_bits:     modem_regs_pkg::RST_RING_CONFIG,
        intrusion_bits:       modem_regs_pkg::RST_INTRUSION,
        gain_select_bits:     modem_regs_pkg::RST_GAIN_SELECT,
        config_one_bits:      modem_regs_pkg::RST_CONFIG_ONE,
        pin_function_a:       modem_regs_pkg::RST_PIN_FUNC_A,
        pin_function_b:       modem_regs_pkg::RST_PIN_FUNC_B,
        pin_data_bits:        modem_regs_pkg::RST_PIN_DATA,
        config_five_bits:     modem_regs_pkg::RST_CONFIG_FIVE,
        dsp_window_select:    modem_regs_pkg::RST_DSP_SELECT,
        test_power_bits:      modem_regs_pkg::RST_TEST_POWER,
        default:              '0
    };

    // ----------------------------------------------------------------
    // Read mux, sampled in the address phase
    // ----------------------------------------------------------------
    always_comb begin
        rd_val = '0;
        case (a_idx)
            modem_regs_pkg::IDX_CARRIER_RETURN: rd_val[7:0] = st.carrier_return_time;
            modem_regs_pkg::IDX_CARRIER_WAIT:   rd_val[7:0] = st.carrier_wait_timeout;
            modem_regs_pkg::IDX_ANSWER_DELAY:   rd_val[7:0] = st.answer_tone_delay;
            modem_regs_pkg::IDX_CALLER_ID:      rd_val[7:0] = st.caller_id_bits;
            modem_regs_pkg::IDX_RING_CONFIG:    rd_val[7:0] = st.ring_config_bits;
            modem_regs_pkg::IDX_INTRUSION:      rd_val[7:0] = st.intrusion_bits;
            modem_regs_pkg::IDX_LINE_VOLTAGE:   rd_val[7:0] = st.line_voltage_status;
            modem_regs_pkg::IDX_GAIN_SELECT:    rd_val[7:0] = st.gain_select_bits;
            modem_regs_pkg::IDX_CONFIG_ONE:     rd_val[7:0] = st.config_one_bits;
            modem_regs_pkg::IDX_PIN_FUNC_A:     rd_val[7:0] = st.pin_function_a;
            modem_regs_pkg::IDX_PIN_FUNC_B:     rd_val[7:0] = st.pin_function_b;
            modem_regs_pkg::IDX_PIN_DATA:       rd_val[7:0] = st.pin_data_bits;
            modem_regs_pkg::IDX_CONFIG_FIVE:    rd_val[7:0] = st.config_five_bits;
            modem_regs_pkg::IDX_DSP_SELECT:     rd_val[7:0] = st.dsp_window_select;
            modem_regs_pkg::IDX_TEST_POWER:     rd_val[7:0] = st.test_power_bits;
            modem_regs_pkg::IDX_DSP_WINDOW_LOW: begin
                // Write-only meanings read as zero
                if (st.dsp_window_select == modem_regs_pkg::SEL_CONTROL) begin // [RULE11] [RULE13]
                    rd_val[7:0] = dsp_status;
                end
            end
            default: rd_val = '0;
        endcase
        if (!a_mapped) begin
            rd_val = '0;
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.dsp.word_load = 1'b0;
        next_st.call_abort    = 1'b0;

        // Bus pipeline: zero wait states, read data registered
        next_st.dphase_valid = aphase && a_mapped;
        next_st.dphase_write = hwrite;
        next_st.dphase_idx   = a_idx;
        if (aphase && !hwrite) begin
            next_st.rdata = rd_val;
        end

        if (wr) begin
            case (w_idx)
                modem_regs_pkg::IDX_CARRIER_RETURN: next_st.carrier_return_time  = wb;
                modem_regs_pkg::IDX_CARRIER_WAIT:   next_st.carrier_wait_timeout = wb;
                modem_regs_pkg::IDX_ANSWER_DELAY:   next_st.answer_tone_delay    = wb;
                modem_regs_pkg::IDX_CALLER_ID:      next_st.caller_id_bits       = wb;
                modem_regs_pkg::IDX_RING_CONFIG:    next_st.ring_config_bits     = wb;
                modem_regs_pkg::IDX_INTRUSION:      next_st.intrusion_bits       = wb;
                modem_regs_pkg::IDX_GAIN_SELECT:    next_st.gain_select_bits     = wb;
                modem_regs_pkg::IDX_CONFIG_ONE:     next_st.config_one_bits      = wb;
                modem_regs_pkg::IDX_PIN_FUNC_A:     next_st.pin_function_a       = wb;
                modem_regs_pkg::IDX_PIN_FUNC_B:     next_st.pin_function_b       = wb;
                modem_regs_pkg::IDX_PIN_DATA:       next_st.pin_data_bits        = wb;
                modem_regs_pkg::IDX_CONFIG_FIVE:    next_st.config_five_bits     = wb;
                modem_regs_pkg::IDX_DSP_SELECT:     next_st.dsp_window_select    = wb; // [RULE6]
                modem_regs_pkg::IDX_TEST_POWER:     next_st.test_power_bits      = wb;
                default: ;
            endcase

            // Shared window; other selector values drop the write
            if (is_reg(w_idx, modem_regs_pkg::IDX_DSP_WINDOW_LOW)) begin
                case (st.dsp_window_select) // [RULE6]
                    modem_regs_pkg::SEL_ADDRESS: next_st.dsp.addr[7:0] = wb;   // [RULE7]
                    modem_regs_pkg::SEL_DATA:    next_st.dsp.word[7:0] = wb;   // [RULE9]
                    modem_regs_pkg::SEL_CONTROL: next_st.dsp.ctrl_low  = wb;   // [RULE12]
                    default: ;
                endcase
            end
            if (is_reg(w_idx, modem_regs_pkg::IDX_DSP_WINDOW_HI)) begin
                case (st.dsp_window_select) // [RULE6]
                    modem_regs_pkg::SEL_ADDRESS: next_st.dsp.addr[15:8] = wb;  // [RULE8]
                    modem_regs_pkg::SEL_DATA: begin
                        // High byte completes the word for the DSP
                        next_st.dsp.word[13:8] = wb[modem_regs_pkg::WORD_HI_W-1:0]; // [RULE10]
                        next_st.dsp.word_load  = 1'b1;
                    end
                    modem_regs_pkg::SEL_CONTROL: next_st.dsp.ctrl_high = wb;   // [RULE12]
                    default: ;
                endcase
            end
        end

        // Line voltage: small readings are treated as no line
        if (line_volts < modem_regs_pkg::MIN_VOLTS &&
            line_volts > -modem_regs_pkg::MIN_VOLTS) begin
            next_st.line_voltage_status = '0; // [RULE5]
        end else begin
            next_st.line_voltage_status = line_volts; // [RULE4]
        end

        // Carrier qualification: any drop restarts the whole interval
        if (!carrier_detect) begin
            next_st.carrier_ok = 1'b0;
            next_st.ret_tmr    = '0;
        end else if (!st.carrier_ok) begin
            if (st.ret_tmr.units == st.carrier_return_time) begin
                next_st.carrier_ok = 1'b1; // [RULE1]
            end else begin
                next_st.ret_tmr = tick(st.ret_tmr, RET_LAST, st.carrier_return_time); // [RULE1]
            end
        end

        // Carrier wait: one abort pulse per waiting period
        if (!carrier_wait || st.carrier_ok) begin
            next_st.wait_tmr   = '0;
            next_st.abort_done = 1'b0;
        end else if (!st.abort_done) begin
            if (st.wait_tmr.units == st.carrier_wait_timeout) begin
                next_st.call_abort = 1'b1; // [RULE2]
                next_st.abort_done = 1'b1;
            end else begin
                next_st.wait_tmr = tick(st.wait_tmr, WAIT_LAST, st.carrier_wait_timeout);
            end
        end

        // Answer tone delay, counted from going off-hook
        if (!(answer_mode && off_hook)) begin
            next_st.ans_tmr        = '0;
            next_st.answer_tone_on = 1'b0;
        end else if (!st.answer_tone_on) begin
            if (st.ans_tmr.units == st.answer_tone_delay) begin
                next_st.answer_tone_on = 1'b1; // [RULE3]
            end else begin
                next_st.ans_tmr = tick(st.ans_tmr, ANS_LAST, st.answer_tone_delay); // [RULE3]
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= RST_ST;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign hrdata         = st.rdata;
    assign hreadyout      = 1'b1;
    assign hresp          = 1'b0;
    assign dsp            = st.dsp;
    assign carrier_ok     = st.carrier_ok;
    assign call_abort     = st.call_abort;
    assign answer_tone_on = st.answer_tone_on;

endmodule // modem_timing_regs
`default_nettype wire

//--- tb/modem_regs_checker.sv
`timescale 1ns/1ns
`default_nettype none
module modem_regs_checker #(
    parameter int RETURN_UNIT_CYC = 4,
    parameter int WAIT_UNIT_CYC   = 8,
    parameter int ANSWER_UNIT_CYC = 6
) (
    input wire logic                      clk,
    input wire logic                      nrst,
    input wire logic                      hsel,
    input wire logic [31:0]               haddr,
    input wire logic [1:0]                htrans,
    input wire logic                      hwrite,
    input wire logic [2:0]                hsize,
    input wire logic                      hready,
    input wire logic [31:0]               hwdata,
    input wire logic [31:0]               hrdata,
    input wire logic                      hreadyout,
    input wire logic                      hresp,
    input wire logic                      carrier_detect,
    input wire logic                      carrier_wait,
    input wire logic                      answer_mode,
    input wire logic                      off_hook,
    input wire logic signed [7:0]         line_volts,
    input wire logic [7:0]                dsp_status,
    input wire modem_regs_pkg::dsp_port_t dsp,
    input wire logic                      carrier_ok,
    input wire logic                      call_abort,
    input wire logic                      answer_tone_on
);
    // ------------------------------------------------------------
    // Selector shadow, updated at the same edge as the real one
    // ------------------------------------------------------------
    logic [7:0] sel;
    logic       sel_wr;
    wire        take = hsel && htrans[1] && hready;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sel    <= 8'h00;
            sel_wr <= 1'b0;
        end else begin
            sel_wr <= take && hwrite && haddr == 32'h3A0;
            if (sel_wr)
                sel <= hwdata[7:0];
        end
    end
    sequence win_wr(a, s);
        take && hwrite && haddr == a && sel == s;
    endsequence
    sequence bus_rd(a, ok);
        take && !hwrite && haddr == a && ok;
    endsequence
    function automatic logic [7:0] lv_f(input logic signed [7:0] v);
        return (v > -8'sd3 && v < 8'sd3) ? 8'h00 : v;
    endfunction
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    addr_low_a: assert property (win_wr(32'h394, 8'h00) |=> ##1
        dsp.addr[7:0] == $past(hwdata[7:0])) else $error("dsp address low byte wrong");
    addr_high_a: assert property (win_wr(32'h398, 8'h00) |=> ##1
        dsp.addr[15:8] == $past(hwdata[7:0])) else $error("dsp address high byte wrong");
    word_low_a: assert property (win_wr(32'h394, 8'h01) |=> ##1
        dsp.word[7:0] == $past(hwdata[7:0])) else $error("dsp word low byte wrong");
    word_high_a: assert property (win_wr(32'h398, 8'h01) |=> ##1
        dsp.word[13:8] == $past(hwdata[5:0])) else $error("dsp word high bits wrong");
    status_rd_a: assert property (bus_rd(32'h394, sel == 8'h02 && $stable(dsp_status))
        |=> hrdata == {24'h000000, $past(dsp_status)}) else $error("dsp status read wrong");
    volts_read_a: assert property (bus_rd(32'h36C, $stable(line_volts)) |=>
        hrdata == {24'h000000, lv_f($past(line_volts))}) else $error("line voltage read wrong");
    carrier_drop_a: assert property (!carrier_detect |=> !carrier_ok)
        else $error("carrier kept after loss");
    abort_pulse_a: assert property (call_abort |-> $past(carrier_wait) ##1 !call_abort)
        else $error("call abort not a single pulse while waiting");
    tone_stop_a: assert property (!(answer_mode && off_hook) |=> !answer_tone_on)
        else $error("answer tone without off-hook answer mode");
    okay_resp_a: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
endmodule // modem_regs_checker

bind modem_timing_regs modem_regs_checker #(
    .RETURN_UNIT_CYC(RETURN_UNIT_CYC), .WAIT_UNIT_CYC(WAIT_UNIT_CYC),
    .ANSWER_UNIT_CYC(ANSWER_UNIT_CYC)
) chk (
    .clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata, .hrdata,
    .hreadyout, .hresp, .carrier_detect, .carrier_wait, .answer_mode, .off_hook,
    .line_volts, .dsp_status, .dsp, .carrier_ok, .call_abort, .answer_tone_on
);
`default_nettype wire

//--- tb/tb_modem_timing_dsp_window_regs.sv
`timescale 1ns/1ns
`default_nettype none
module tb_modem_timing_dsp_window_regs;
    logic              clk = 1'b0;
    logic              nrst = 1'b0;
    logic [31:0]       haddr = 32'h0;
    logic [1:0]        htrans = 2'h0;
    logic              hwrite = 1'b0;
    logic [31:0]       hwdata = 32'h0;
    logic              carrier_detect = 1'b0;
    logic              carrier_wait = 1'b0;
    logic              answer_mode = 1'b0;
    logic              off_hook = 1'b0;
    logic signed [7:0] line_volts = 8'sh00;
    logic [7:0]        dsp_status = 8'h00;
    logic [31:0]       hrdata, r;
    logic              hreadyout, hresp, carrier_ok, call_abort, answer_tone_on;
    modem_regs_pkg::dsp_port_t dsp;
    integer            seed = 32'hD74E3ACB;
    int                bad_count = 0, cmp_count = 0, n, i, j;
    logic [7:0]        d, d2;
    logic signed [7:0] v;
    logic [45:0]       ew = '0;
    logic [7:0]        idx [14] = '{8'h37, 8'h39, 8'h3A, 8'h3C, 8'h62, 8'h82, 8'hDF, 8'hE0,
                                    8'hE1, 8'hE2, 8'hE3, 8'hE4, 8'hE8, 8'hEB};
    logic [7:0]        m [14] = '{8'h20, 8'h3C, 8'h00, 8'h01, 8'h41, 8'h08, 8'h0C, 8'h22,
                                  8'h0E, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic signed [7:0] bnd [6] = '{8'shFD, 8'shFE, 8'sh02, 8'sh03, 8'sh80, 8'sh7F};

    modem_timing_regs #(.RETURN_UNIT_CYC(4), .WAIT_UNIT_CYC(8), .ANSWER_UNIT_CYC(6)) dut (
        .clk, .nrst, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .carrier_detect,
        .carrier_wait, .answer_mode, .off_hook, .line_volts, .dsp_status, .dsp,
        .carrier_ok, .call_abort, .answer_tone_on
    );
    always #25 clk = ~clk;

    function automatic logic [31:0] ad(input logic [7:0] x);
        return {22'h0, x, 2'h0};
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Single transfer; the extra leading edge keeps transfers apart
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] dat);
        @(posedge clk);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= dat;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic meas(input int k);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (n < 1000 && !(k == 0 ? carrier_ok : k == 1 ? call_abort : answer_tone_on));
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (idx[k]) begin
            bus(1'b0, ad(idx[k]), 32'h0);
            chk(r, {24'h0, m[k]});
        end
        repeat (24) begin
            i = $unsigned($random(seed)) % 14;
            j = $unsigned($random(seed)) % 14;
            d = 8'($random(seed));
            bus(1'b1, ad(idx[i]), {24'($random(seed)), d});
            m[i] = d;
            bus(1'b0, ad(idx[j]), 32'h0);
            chk(r, {24'h0, m[j]});
        end
        // Refused accesses: line status is read-only, high address bits unmapped
        bus(1'b1, ad(8'h37) | 32'h400, 32'hFF);
        bus(1'b1, ad(8'hDB), 32'h7F);
        bus(1'b0, ad(8'h37), 32'h0);
        chk(r, {24'h0, m[0]});
        bus(1'b0, ad(8'h37) | 32'h400, 32'h0);
        chk(r, 32'h0);
        for (int k = 0; k < 12; k++) begin
            v = (k < 6) ? bnd[k] : 8'($random(seed));
            @(posedge clk);
            line_volts <= v;
            bus(1'b0, ad(8'hDB), 32'h0);
            chk(r, {24'h0, (v > -3 && v < 3) ? 8'h00 : v});
        end
        for (int s = 0; s < 4; s++) begin
            d = 8'($random(seed));
            d2 = 8'($random(seed));
            bus(1'b1, ad(8'hE8), 32'(s));
            bus(1'b1, ad(8'hE5), {24'h0, d});
            bus(1'b1, ad(8'hE6), {24'h0, d2});
            if (s == 0) ew[45:30] = {d2, d};
            if (s == 1) ew[29:16] = {d2[5:0], d};
            if (s == 2) ew[15:0] = {d, d2};
            @(negedge clk);
            chk(dsp, {ew, s == 1});
            @(posedge clk);
            dsp_status <= 8'($random(seed));
            bus(1'b0, ad(8'hE5), 32'h0);
            if (s < 3) chk(r, (s == 2) ? {24'h0, dsp_status} : 32'h0);
            bus(1'b0, ad(8'hE6), 32'h0);
            chk(r, 32'h0);
        end
        // Carrier qualification restarts after a short dropout
        bus(1'b1, ad(8'h37), 32'h3);
        bus(1'b1, ad(8'h39), 32'h3C);
        carrier_detect <= 1'b1;
        repeat (5) @(posedge clk);
        carrier_detect <= 1'b0;
        @(posedge clk);
        carrier_detect <= 1'b1;
        meas(0);
        chk(n >= 12 && n <= 14, 1);
        @(posedge clk);
        carrier_detect <= 1'b0;
        carrier_wait <= 1'b1;
        meas(1);
        chk(n >= 480 && n <= 484, 1);
        meas(1);
        chk(n, 1000);
        bus(1'b1, ad(8'h3A), 32'h3);
        carrier_wait <= 1'b0;
        answer_mode <= 1'b1;
        off_hook <= 1'b1;
        meas(2);
        chk(n >= 18 && n <= 20, 1);
        @(posedge clk);
        off_hook <= 1'b0;
        repeat (3) @(posedge clk);
        summarize();
    end
    initial begin
        #2000000;
        bad_count++;
        $display("ERROR %0t watchdog expired", $time);
        summarize();
    end
endmodule // tb_modem_timing_dsp_window_regs
`default_nettype wire
